/* design/isolated_input_spi_port.sv */
// Logic-side serial port of an eight-channel isolated input device
// What this block does
// - Two straps pick frame length 24 or 16, CRC, and chaining.
// - Chip select falling snapshots all eight inputs and opens the frame.
// - Input sampled on clock rise, output changes on clock fall.
// - First bit is the MSB; zero means read, one means write.
// - Clock edges while chip select is high are ignored.
// - First eight output bits are the snapshot, channel 8 first.
// - Modes 0 and 1 writes return wire-break status as second byte.
// - Modes 0 and 1 decode reads mid-frame and return data same frame.
// - Chaining modes decode the instruction only at chip select rise.
// - Chaining reads return register data in the next frame's byte two.
// - Clock count not multiple of eight discards frame, sets count error.
// - Field ready output goes low once the field side is powered.
// - Ready input high forces ready indication low and outputs default, except the field alarm and field ready outputs.
// - Host alarm is open-drain, mirroring the field alarm input.
// - Output enable pin low drives serial out even when unselected.
// - Chip select low enables field interfaces and the serial out driver.
// - Chip select, clock and serial in are forwarded to the field side.
// - Field serial return is forwarded to the host serial out while chip select is high.
// - Snapshot pin low captures inputs for devices on other selects.
// - Five-bit check over first 19 bits plus 00111, polynomial 0x35.
// - Frames failing the check are ignored; CRC error holds until good.
`timescale 1ns/100ps

module cmd_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_type;
  fifo_state_type s_reg, s_next;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign o_ready = (s_reg.cnt != FULL);
  assign o_valid = (s_reg.cnt != '0);
  assign o_data = s_reg.mem[s_reg.rp];

  always_comb begin
    s_next = s_reg;
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    if (push) begin
      s_next.mem[s_reg.wp] = i_data;
      s_next.wp = bump(s_reg.wp);
    end
    if (pop) begin
      s_next.rp = bump(s_reg.rp);
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end
endmodule

module isolated_input_spi_port
  import iso_spi_pkg::*;
(
  // System
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Host-side pins
  input wire logic i_host_chip_select_n,
  input wire logic i_host_serial_clock,
  input wire logic i_host_serial_in,
  input wire logic i_host_snapshot_n,
  input wire logic i_serial_out_enable_n,
  input wire logic i_mode_strap_lo,
  input wire logic i_mode_strap_hi,
  output logic o_host_serial_out,
  output logic o_host_serial_out_en,
  output logic o_host_alarm_n_out,
  output logic o_host_alarm_n_oe,
  output logic o_host_field_ready,
  // Field-side pins
  input wire logic i_field_serial_return,
  input wire logic i_field_alarm_iso_in_n,
  input wire logic i_field_ready_iso_in_n,
  input wire logic i_field_powered,
  output logic o_field_chip_select_n,
  output logic o_field_serial_clock,
  output logic o_field_forwarded_serial_in,
  output logic o_field_alarm_out_n_oe,
  output logic o_field_ready_out_n_oe,
  // Device core state, same clock
  input wire logic [7:0] i_input_states,
  input wire logic [7:0] i_wire_break_status,
  input wire logic [2:0] i_supply_flags,
  input wire logic [7:0] i_rd_data,
  output logic [6:0] o_rd_addr,
  // Committed register writes
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output wr_cmd_type o_wr_cmd,
  // Status
  input wire logic i_status_clr,
  output logic o_clock_count_error,
  output logic o_crc_error,
  output logic o_write_lost
);
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] filt;
    phase_type phase;
    logic [1:0] mode;
    logic [7:0] cnt;
    logic full;
    logic [23:0] rx;
    logic [23:0] tx;
    logic [7:0] snap;
    logic latched;
    logic [7:0] latch_val;
    logic prev_rd;
    logic [6:0] rd_addr;
    logic pend;
    wr_cmd_type pend_cmd;
    logic cnt_err;
    logic crc_err;
    logic lost;
    logic sdo;
    logic sdo_en;
    logic fcs_n;
    logic fsck;
    logic field_serial_in;
    logic alarm_oe;
    logic rdy_oe;
    logic host_rdy;
    logic falarm_oe;
  } port_state_type;

  port_state_type s_reg, s_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [PIN_W-1:0] pins, filt_n;
  logic cs_fall, cs_rise, sck_rise, sck_fall, snap_fall, ready;
  logic end_ok, crc_ok, new_wr, cnt_set, lost_set;
  logic [7:0] cnt_inc;
  logic [15:0] cmd;
  logic fifo_ready;

  function automatic logic [4:0] crc5(input logic [18:0] d);
    logic [23:0] m;
    logic [4:0] c;
    logic fb;
    m = {d, CRC_PAD};
    c = '0;
    for (int i = FRAME_LONG - 1; i >= 0; i--) begin
      // Plain long division: the pad stands in for the augmenting zeros
      fb = c[CRC_BITS-1];
      c = {c[3:0], m[i]} ^ (fb ? CRC_POLY : 5'h00);
    end
    crc5 = c;
  endfunction

  // Frame image, MSB aligned; short frames leave the tail zero
  function automatic logic [23:0] frame_img(input logic [7:0] b1,
      input logic [7:0] b2, input logic [2:0] fl, input logic short_f);
    frame_img = short_f ? {b1, b2, 8'h00}
                        : {b1, b2, fl, crc5({b1, b2, fl})};
  endfunction

  // Reset released through two flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign pins = {i_mode_strap_hi, i_mode_strap_lo, i_field_powered,
                 i_field_serial_return, i_serial_out_enable_n,
                 i_field_alarm_iso_in_n, i_field_ready_iso_in_n,
                 i_host_snapshot_n, i_host_serial_in, i_host_serial_clock,
                 i_host_chip_select_n};

  always_comb begin
    s_next = s_reg;
    cmd = '0;
    crc_ok = 1'b0;
    end_ok = 1'b0;
    new_wr = 1'b0;
    cnt_set = 1'b0;
    lost_set = 1'b0;
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    // A level counts once the second and third stages agree
    filt_n = (s_reg.sync2 & s_reg.sync3)
           | (s_reg.filt & (s_reg.sync2 | s_reg.sync3));
    s_next.filt = filt_n;
    ready = !filt_n[P_RDY];
    cs_fall = s_reg.filt[P_CS] && !filt_n[P_CS];
    cs_rise = !s_reg.filt[P_CS] && filt_n[P_CS];
    sck_rise = !s_reg.filt[P_SCK] && filt_n[P_SCK];
    sck_fall = s_reg.filt[P_SCK] && !filt_n[P_SCK];
    snap_fall = s_reg.filt[P_SNAP] && !filt_n[P_SNAP];
    cnt_inc = s_reg.cnt + CNT_ONE;

    if (snap_fall) begin
      s_next.latched = 1'b1;
      s_next.latch_val = i_input_states;
    end
    if (s_reg.pend && fifo_ready) begin
      s_next.pend = 1'b0;
    end

    case (s_reg.phase)
      PH_IDLE: begin
        s_next.mode = {filt_n[P_M1], filt_n[P_M0]};
        if (cs_fall && ready) begin
          s_next.snap = s_reg.latched ? s_reg.latch_val : i_input_states;
          s_next.latched = 1'b0;
          s_next.cnt = '0;
          s_next.full = 1'b0;
          s_next.rx = '0;
          // Chained read answer or wire-break status in byte two
          s_next.tx = frame_img(s_next.snap,
              (s_next.mode[MODE_CHAIN] && s_reg.prev_rd) ? i_rd_data
                                                         : i_wire_break_status,
              i_supply_flags, s_next.mode[MODE_SHORT]);
          s_next.phase = PH_SHIFT;
        end
      end
      PH_SHIFT: begin
        // Clock edges only count inside an open frame
        if (sck_rise) begin
          s_next.rx = {s_reg.rx[22:0], filt_n[P_SDI]};
          s_next.cnt = cnt_inc;
          if (cnt_inc == (s_reg.mode[MODE_SHORT] ? CNT_SHORT : CNT_LONG)) begin
            s_next.full = 1'b1;
          end
          // Early decode of a read on the eighth rise
          if (!s_reg.mode[MODE_CHAIN] && cnt_inc == CNT_BYTE
              && !s_reg.rx[6]) begin
            s_next.rd_addr = {s_reg.rx[5:0], filt_n[P_SDI]};
            s_next.phase = PH_FETCH;
          end
        end
        if (sck_fall) begin
          s_next.tx = {s_reg.tx[22:0], 1'b0};
        end
        if (cs_rise) begin
          s_next.phase = PH_IDLE;
          if (s_reg.cnt[2:0] != CNT_MOD8) begin
            s_next.cnt_err = 1'b1;
            cnt_set = 1'b1;
          end else if (s_reg.full) begin
            cmd = s_reg.mode[MODE_SHORT] ? s_reg.rx[15:0] : s_reg.rx[23:8];
            crc_ok = s_reg.mode[MODE_SHORT]
                  || (s_reg.rx[4:0] == crc5(s_reg.rx[23:5]));
            if (!s_reg.mode[MODE_SHORT]) begin
              s_next.crc_err = !crc_ok;
            end
            end_ok = crc_ok;
          end
        end
        if (end_ok) begin
          s_next.prev_rd = 1'b0;
          if (cmd[15]) begin
            new_wr = 1'b1;
          end else if (s_reg.mode[MODE_CHAIN]) begin
            s_next.prev_rd = 1'b1;
            s_next.rd_addr = cmd[14:8];
          end
        end
      end
      PH_FETCH: begin
        // Address stands on o_rd_addr this cycle; data is taken now
        s_next.tx = frame_img(s_reg.snap, i_rd_data, i_supply_flags,
            s_reg.mode[MODE_SHORT]) << LOAD_SHIFT;
        s_next.phase = cs_rise ? PH_IDLE : PH_SHIFT;
      end
      default: begin
        s_next.phase = PH_IDLE;
      end
    endcase

    if (new_wr) begin
      // Only one write waits outside the FIFO; a second is dropped
      if (s_next.pend) begin
        s_next.lost = 1'b1;
        lost_set = 1'b1;
      end else begin
        s_next.pend = 1'b1;
        s_next.pend_cmd = '{addr: cmd[14:8], data: cmd[7:0]};
      end
    end
    // Set wins over clear
    if (i_status_clr) begin
      s_next.cnt_err = cnt_set;
      s_next.lost = lost_set;
    end

    if (!ready) begin
      s_next.phase = PH_IDLE;
    end
    s_next.host_rdy = ready;
    s_next.rdy_oe = filt_n[P_PWR];
    s_next.fcs_n = filt_n[P_CS] || !ready;
    s_next.fsck = filt_n[P_SCK] && ready;
    s_next.field_serial_in = filt_n[P_SDI] && ready;
    // Own data while selected, shared return otherwise
    s_next.sdo = !filt_n[P_CS] ? s_next.tx[TX_MSB]
                               : filt_n[P_RET];
    s_next.sdo_en = ready
        && (!filt_n[P_CS] || !filt_n[P_OEN]);
    s_next.alarm_oe = ready && !filt_n[P_ALARM];
    s_next.falarm_oe = s_next.crc_err || s_next.cnt_err;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.sync1 <= PIN_IDLE;
      s_reg.sync2 <= PIN_IDLE;
      s_reg.sync3 <= PIN_IDLE;
      s_reg.filt <= PIN_IDLE;
      s_reg.fcs_n <= 1'b1;
      s_reg.phase <= PH_IDLE;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  cmd_fifo #(
    .WIDTH($bits(wr_cmd_type)),
    .DEPTH(8)
  ) u_fifo (
    .i_clk(i_clk_sys),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .i_valid(s_reg.pend),
    .o_ready(fifo_ready),
    .i_data(s_reg.pend_cmd),
    .o_valid(o_wr_valid),
    .i_ready(i_wr_ready),
    .o_data(o_wr_cmd)
  );

  assign o_host_serial_out = s_reg.sdo;
  assign o_host_serial_out_en = s_reg.sdo_en;
  assign o_host_alarm_n_out = 1'b0;
  assign o_host_alarm_n_oe = s_reg.alarm_oe;
  assign o_host_field_ready = s_reg.host_rdy;
  assign o_field_chip_select_n = s_reg.fcs_n;
  assign o_field_serial_clock = s_reg.fsck;
  assign o_field_forwarded_serial_in = s_reg.field_serial_in;
  assign o_field_alarm_out_n_oe = s_reg.falarm_oe;
  assign o_field_ready_out_n_oe = s_reg.rdy_oe;
  assign o_rd_addr = s_reg.rd_addr;
  assign o_clock_count_error = s_reg.cnt_err;
  assign o_crc_error = s_reg.crc_err;
  assign o_write_lost = s_reg.lost;

  // Checks
  logic [22:0] tx_low;
  logic cs_bad;
  assign tx_low = s_reg.tx[22:0];
  assign cs_bad = cs_rise && s_reg.phase == PH_SHIFT
               && s_reg.cnt[2:0] != CNT_MOD8;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n || !i_clk_en);

  snap_open_a: assert property (cs_fall && ready && s_reg.phase == PH_IDLE
      |=> s_reg.phase == PH_SHIFT && !s_reg.latched)
    else $error("frame did not open on select");
  first_bit_a: assert property (cs_fall && ready && s_reg.phase == PH_IDLE
      |=> o_host_serial_out == s_reg.snap[7])
    else $error("first output bit is not channel 8");
  fall_shift_a: assert property (s_reg.phase == PH_SHIFT && sck_fall
      && !sck_rise |=> s_reg.tx[23:1] == $past(tx_low))
    else $error("output did not shift on falling clock");
  count_err_a: assert property (cs_bad
      |=> o_clock_count_error && !$rose(s_reg.pend))
    else $error("bad clock count not flagged");
  early_read_a: assert property (s_reg.phase == PH_SHIFT && sck_rise
      && !s_reg.mode[MODE_CHAIN] && cnt_inc == CNT_BYTE && !s_reg.rx[6]
      && !cs_rise |=> s_reg.phase == PH_FETCH ##1 s_reg.phase != PH_FETCH)
    else $error("mid-frame read not fetched");
  chain_late_a: assert property (s_reg.mode[MODE_CHAIN]
      && s_reg.phase != PH_IDLE |-> s_reg.phase != PH_FETCH)
    else $error("chained mode decoded early");
  ready_gate_a: assert property (!o_host_field_ready
      |-> !o_host_serial_out_en && !o_host_alarm_n_oe
          && o_field_chip_select_n)
    else $error("outputs active while field not ready");
  oe_pin_a: assert property (ready && $fell(s_reg.filt[P_OEN])
      |=> o_host_serial_out_en)
    else $error("output enable pin ignored");
  snap_pin_a: assert property (snap_fall
      |=> s_reg.latched && s_reg.latch_val == $past(i_input_states))
    else $error("snapshot pin missed");
  crc_drop_a: assert property (cs_rise && s_reg.phase == PH_SHIFT
      && s_reg.full && !s_reg.mode[MODE_SHORT]
      && s_reg.cnt[2:0] == CNT_MOD8
      && s_reg.rx[4:0] != crc5(s_reg.rx[23:5])
      |=> o_crc_error && !$rose(s_reg.pend))
    else $error("corrupt frame not ignored");

  read_frame_c: cover property (s_reg.phase == PH_FETCH);
  write_frame_c: cover property ($rose(o_wr_valid));
  count_err_c: cover property ($rose(o_clock_count_error));
  chain_read_c: cover property (s_reg.prev_rd && cs_fall);
endmodule

/* design/iso_spi_pkg.sv */
// Constants, types and carriers for the isolated input serial port
package iso_spi_pkg;
  // Frame geometry
  localparam int FRAME_LONG = 24;
  localparam int FRAME_SHORT = 16;
  localparam int BYTE_BITS = 8;
  localparam int CRC_BITS = 5;
  localparam int CRC_DATA_BITS = 19;
  localparam int TX_MSB = 23;
  localparam int LOAD_SHIFT = 7;
  localparam logic [4:0] CRC_POLY = 5'h15;
  localparam logic [4:0] CRC_PAD = 5'h07;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_LONG = 8'h18;
  localparam logic [7:0] CNT_SHORT = 8'h10;
  localparam logic [7:0] CNT_BYTE = 8'h08;
  localparam logic [2:0] CNT_MOD8 = 3'h0;
  // Strap mode bits: bit 0 short frame, bit 1 chaining
  localparam int MODE_SHORT = 0;
  localparam int MODE_CHAIN = 1;
  // Synchronised pin vector layout
  localparam int P_CS = 0;
  localparam int P_SCK = 1;
  localparam int P_SDI = 2;
  localparam int P_SNAP = 3;
  localparam int P_RDY = 4;
  localparam int P_ALARM = 5;
  localparam int P_OEN = 6;
  localparam int P_RET = 7;
  localparam int P_PWR = 8;
  localparam int P_M0 = 9;
  localparam int P_M1 = 10;
  localparam int PIN_W = 11;
  localparam logic [10:0] PIN_IDLE = 11'h079;

  typedef enum logic [1:0] {PH_IDLE, PH_SHIFT, PH_FETCH} phase_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } wr_cmd_type;
endpackage

/* verif/spi_host_model.sv */
// Host-side serial master model for the port's link pins
`timescale 1ns/100ps
module spi_host_model (
  // Link pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // Raw pin control for stray clocks and forwarding
  task automatic drive(input logic cs, input logic sck, input logic di);
    o_cs_n = cs;
    o_sclk = sck;
    o_sdi = di;
  endtask
  // One frame of n bits, clock standing low around select
  task automatic frame(input int n, input logic [23:0] d,
                       output logic [23:0] r);
    r = 24'h000000;
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = d[i];
      #62.5 o_sclk = 1'b1;
      r = {r[22:0], i_sdo};
      #62.5 o_sclk = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    o_sdi = ~o_sdi;
    #200;
  endtask
endmodule

/* verif/isolated_input_spi_port_tb.sv */
// Self-checking bench for the isolated input serial port
`timescale 1ns/100ps
module isolated_input_spi_port_tb;
  import iso_spi_pkg::*;
  typedef struct packed {
    logic [1:0] md;
    logic w;
    logic [6:0] a;
    logic [7:0] d;
    logic chk;
  } row_type;
  // Chain groups open with an unchecked write to settle history
  localparam row_type ROWS [11] = '{
    '{2'h1, 1'b0, 7'h12, 8'h00, 1'b1}, '{2'h1, 1'b1, 7'h05, 8'h9A, 1'b1},
    '{2'h0, 1'b1, 7'h33, 8'hC3, 1'b1}, '{2'h0, 1'b0, 7'h21, 8'h00, 1'b1},
    '{2'h2, 1'b1, 7'h06, 8'h11, 1'b0}, '{2'h2, 1'b0, 7'h44, 8'h00, 1'b1},
    '{2'h2, 1'b0, 7'h55, 8'h00, 1'b1}, '{2'h2, 1'b1, 7'h07, 8'h22, 1'b1},
    '{2'h3, 1'b1, 7'h08, 8'h33, 1'b0}, '{2'h3, 1'b0, 7'h66, 8'h00, 1'b1},
    '{2'h3, 1'b1, 7'h09, 8'h44, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, sdi, sdo, sdo_en, al_oe, al_out, fld_rdy;
  logic fcs_n, fsck, field_serial_in, fal_oe, frdy_oe, wr_valid, cnt_err, crc_err, lost;
  logic snap_n = 1'b1;
  logic oen_n = 1'b1;
  logic m_lo = 1'b0;
  logic m_hi = 1'b0;
  logic ret = 1'b0;
  logic al_in_n = 1'b1;
  logic rdy_in_n = 1'b0;
  logic pwr = 1'b1;
  logic wr_ready = 1'b0;
  logic st_clr = 1'b0;
  logic [7:0] ins = 8'hA5;
  logic [7:0] wb = 8'h3C;
  logic [2:0] sup = 3'h5;
  logic [7:0] rd_data, b2;
  logic [6:0] rd_addr, pa;
  logic [23:0] r;
  logic pend;
  row_type row;
  wr_cmd_type wr_cmd;
  int miscompares = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  function automatic logic [7:0] rdv(input logic [6:0] a);
    return {1'b1, a} ^ 8'h3C;
  endfunction
  assign rd_data = rdv(rd_addr);

  isolated_input_spi_port dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
    .i_host_chip_select_n(cs_n), .i_host_serial_clock(sclk),
    .i_host_serial_in(sdi), .i_host_snapshot_n(snap_n),
    .i_serial_out_enable_n(oen_n), .i_mode_strap_lo(m_lo),
    .i_mode_strap_hi(m_hi), .o_host_serial_out(sdo),
    .o_host_serial_out_en(sdo_en), .o_host_alarm_n_out(al_out),
    .o_host_alarm_n_oe(al_oe), .o_host_field_ready(fld_rdy),
    .i_field_serial_return(ret), .i_field_alarm_iso_in_n(al_in_n),
    .i_field_ready_iso_in_n(rdy_in_n), .i_field_powered(pwr),
    .o_field_chip_select_n(fcs_n), .o_field_serial_clock(fsck),
    .o_field_forwarded_serial_in(field_serial_in), .o_field_alarm_out_n_oe(fal_oe),
    .o_field_ready_out_n_oe(frdy_oe), .i_input_states(ins),
    .i_wire_break_status(wb), .i_supply_flags(sup), .i_rd_data(rd_data),
    .o_rd_addr(rd_addr), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_cmd(wr_cmd), .i_status_clr(st_clr),
    .o_clock_count_error(cnt_err), .o_crc_error(crc_err),
    .o_write_lost(lost)
  );
  spi_host_model host (
    .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Long division of the 19 bits plus pad by x5+x4+x2+1
  function automatic logic [4:0] crc5(input logic [18:0] d);
    logic [5:0] c;
    logic [23:0] m;
    c = 6'h00;
    m = {d, CRC_PAD};
    for (int i = 23; i >= 0; i--) begin
      c = {c[4:0], m[i]};
      if (c[5]) c = c ^ 6'h35;
    end
    return c[4:0];
  endfunction
  function automatic logic [23:0] exp_out(input logic [1:0] md,
                                          input logic [7:0] b);
    if (md[MODE_SHORT]) return {8'h00, ins, b};
    return {ins, b, sup, crc5({ins, b, sup})};
  endfunction
  task automatic xfer(input logic [1:0] md, input logic w,
      input logic [6:0] a, input logic [7:0] d, input logic bad,
      output logic [23:0] q);
    logic [23:0] f;
    {m_hi, m_lo} = md;
    tick(8);
    if (md[MODE_SHORT]) f = {8'h00, w, a, d};
    else f = {w, a, d, 3'h0, crc5({w, a, d, 3'h0}) ^ {4'h0, bad}};
    host.frame(md[MODE_SHORT] ? 16 : 24, f, q);
  endtask
  // Waits for a committed write, compares it and pops it
  task automatic take_wr(input logic [14:0] e);
    int k;
    k = 0;
    // Let an edge pass so back-to-back calls never re-drive wr_ready
    tick(1);
    while (wr_valid !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    if (k == 40) begin
      miscompares++;
      $display("Error wr_valid expected 1 seen %b", wr_valid);
      finish_test();
    end else begin
      check("wr_cmd", 24'(e), 24'(wr_cmd));
      wr_ready = 1'b1;
      tick(1);
      wr_ready = 1'b0;
    end
  endtask

  initial begin
    tick(1);
    check("rst_fcs_n", 24'h1, 24'(fcs_n));
    check("rst_wr_valid", 24'h0, 24'(wr_valid));
    tick(1);
    rst_n = 1'b1;
    tick(12);
    check("field_ready", 24'h1, 24'(fld_rdy));
    pend = 1'b0;
    pa = 7'h00;
    for (int i = 0; i < 11; i++) begin
      row = ROWS[i];
      xfer(row.md, row.w, row.a, row.d, 1'b0, r);
      if (row.md[MODE_CHAIN]) b2 = pend ? rdv(pa) : wb;
      else b2 = row.w ? wb : rdv(row.a);
      if (row.chk) check("frame_out", exp_out(row.md, b2), r);
      if (row.w) take_wr({row.a, row.d});
      else check("rd_addr", 24'(row.a), 24'(rd_addr));
      pend = !row.w;
      pa = row.a;
    end
    for (int v = 0; v < 2; v++) begin
      al_in_n = v[0];
      pwr = !v[0];
      tick(8);
      check("alarm_oe", 24'(!v[0]), 24'(al_oe));
      check("alarm_out", 24'h0, 24'(al_out));
      check("ready_out_oe", 24'(!v[0]), 24'(frdy_oe));
    end
    ins = 8'h5A;
    snap_n = 1'b0;
    tick(8);
    snap_n = 1'b1;
    ins = 8'h0F;
    xfer(2'h1, 1'b0, 7'h12, 8'h00, 1'b0, r);
    check("snap_byte", 24'h5A, 24'(r[15:8]));
    fork
      xfer(2'h1, 1'b0, 7'h12, 8'h00, 1'b0, r);
      begin
        tick(70);
        ins = 8'hF0;
      end
    join
    check("select_snap", 24'h0F, 24'(r[15:8]));
    host.frame(12, 24'h000FFF, r);
    check("count_err", 24'h1, 24'(cnt_err));
    check("alarm_out_oe", 24'h1, 24'(fal_oe));
    check("count_wr", 24'h0, 24'(wr_valid));
    st_clr = 1'b1;
    tick(1);
    st_clr = 1'b0;
    tick(4);
    check("count_clr", 24'h0, 24'(cnt_err));
    xfer(2'h0, 1'b1, 7'h11, 8'h77, 1'b1, r);
    check("crc_err", 24'h1, 24'(crc_err));
    check("crc_wr", 24'h0, 24'(wr_valid));
    xfer(2'h0, 1'b0, 7'h11, 8'h00, 1'b0, r);
    check("crc_clr", 24'h0, 24'(crc_err));
    for (int k = 0; k < 6; k++) begin
      host.drive(1'b1, 1'b1, 1'b1);
      tick(8);
      check("fwd_sck", 24'h1, 24'(fsck));
      host.drive(1'b1, 1'b0, 1'b0);
      tick(8);
    end
    xfer(2'h1, 1'b1, 7'h2A, 8'h5C, 1'b0, r);
    check("stray_out", {8'h00, ins, wb}, r);
    take_wr({7'h2A, 8'h5C});
    host.drive(1'b0, 1'b0, 1'b1);
    tick(8);
    check("fwd_cs_n", 24'h0, 24'(fcs_n));
    check("fwd_sdi", 24'h1, 24'(field_serial_in));
    check("sel_out_en", 24'h1, 24'(sdo_en));
    host.drive(1'b1, 1'b0, 1'b0);
    oen_n = 1'b0;
    for (int v = 0; v < 2; v++) begin
      ret = v[0];
      tick(8);
      check("shared_en", 24'h1, 24'(sdo_en));
      check("return_fwd", 24'(v[0]), 24'(sdo));
    end
    oen_n = 1'b1;
    tick(8);
    check("idle_en", 24'h0, 24'(sdo_en));
    rdy_in_n = 1'b1;
    tick(8);
    check("not_ready", 24'h0, 24'(fld_rdy));
    check("nr_fcs_n", 24'h1, 24'(fcs_n));
    xfer(2'h1, 1'b1, 7'h01, 8'h01, 1'b0, r);
    check("nr_wr", 24'h0, 24'(wr_valid));
    rdy_in_n = 1'b0;
    tick(8);
    check("ready_back", 24'h1, 24'(fld_rdy));
    // Far side stalls while ten writes arrive; the tenth is dropped
    for (int k = 0; k < 10; k++) begin
      xfer(2'h1, 1'b1, 7'(k), 8'(k), 1'b0, r);
      if (k == 8) check("lost_9", 24'h0, 24'(lost));
    end
    check("lost_10", 24'h1, 24'(lost));
    for (int k = 0; k < 9; k++) take_wr({7'(k), 8'(k)});
    tick(4);
    check("fifo_empty", 24'h0, 24'(wr_valid));
    finish_test();
  end
endmodule
